// file: shared/clsbo_pkg.sv
// Purpose: Shared constants, types and helpers for the load/store and bit-operation execution unit
// Assumes: 32 x 8 working registers, pointer pairs in registers 26..31, 16-bit data space
// Notes:   Flag register layout is I T H S V N Z C from bit 7 down to bit 0
// Behaviour
// - Post-increment pointer load reads, then bumps pointer
// - Pre-decrement pointer load drops pointer, then reads
// - Offset load reads pointer plus displacement, unchanged
// - Absolute load fetches instruction address, flags untouched
// - Post-increment pointer write stores, then bumps pointer
// - Pre-decrement pointer write drops pointer, then stores
// - Offset write stores at pointer plus displacement
// - Absolute write stores at instruction address, flags untouched
// - Stack save writes register in two cycles
// - Stack restore loads register in two cycles
// - I/O bit raise sets one bit only
// - I/O bit lower clears one bit only
// - Rotate up through carry, update flags, one cycle
// - Rotate down through carry, update flags, one cycle
// - Copy register bit into transfer flag
// - Copy transfer flag into register bit
// - Half-carry flag set or clear alone
// - Overflow flag set or clear alone
// - Signed test flag set or clear alone
package clsbo_pkg;

	localparam int unsigned DATA_W   = 8;           // Register and memory data width
	localparam int unsigned ADDR_W   = 16;          // Data space address width
	localparam int unsigned DISP_W   = 6;           // Unsigned displacement width
	localparam int unsigned REG_N    = 32;          // Working register count

	// Low byte index of each pointer pair
	localparam logic [4:0] PTR_X_LO = 5'h1a;
	localparam logic [4:0] PTR_Y_LO = 5'h1c;
	localparam logic [4:0] PTR_Z_LO = 5'h1e;

	// Flag register bit positions
	localparam int unsigned FLAG_C = 0;
	localparam int unsigned FLAG_Z = 1;
	localparam int unsigned FLAG_N = 2;
	localparam int unsigned FLAG_V = 3;
	localparam int unsigned FLAG_S = 4;
	localparam int unsigned FLAG_H = 5;
	localparam int unsigned FLAG_T = 6;
	localparam int unsigned FLAG_I = 7;

	// Reset values and fixed offsets
	localparam logic [7:0]  FLAGS_RESET = 8'h00;
	localparam logic [7:0]  REG_RESET   = 8'h00;
	localparam logic [15:0] SP_RESET    = 16'h00ff;     // Plain default, top of a small memory
	localparam logic [15:0] IO_BASE     = 16'h0020;     // I/O register 0 in data space
	localparam logic [15:0] PTR_STEP    = 16'h0001;     // Pointer and stack step

	// Operations
	typedef enum logic [4:0] {
		OP_NOP                  = 5'h00,
		OP_POINTER_LOAD         = 5'h01,
		OP_POINTER_WRITE        = 5'h02,
		OP_OFFSET_LOAD          = 5'h03,
		OP_OFFSET_WRITE         = 5'h04,
		OP_ABSOLUTE_LOAD        = 5'h05,
		OP_ABSOLUTE_WRITE       = 5'h06,
		OP_STACK_SAVE           = 5'h07,
		OP_STACK_RESTORE        = 5'h08,
		OP_IO_BIT_RAISE         = 5'h09,
		OP_IO_BIT_LOWER         = 5'h0a,
		OP_CARRY_ROTATE_UP      = 5'h0b,
		OP_CARRY_ROTATE_DOWN    = 5'h0c,
		OP_BIT_TO_TRANSFER_FLAG = 5'h0d,
		OP_TRANSFER_FLAG_TO_BIT = 5'h0e,
		OP_FLAG_RAISE           = 5'h0f,
		OP_FLAG_LOWER           = 5'h10
	} clsbo_op_t;

	// Pointer pair select and addressing mode
	typedef enum logic [1:0] {PTR_X = 2'h0, PTR_Y = 2'h1, PTR_Z = 2'h2} clsbo_ptr_t;
	typedef enum logic [1:0] {MODE_PLAIN = 2'h0, MODE_POST_INC = 2'h1, MODE_PRE_DEC = 2'h2} clsbo_mode_t;

	// Sequencer states
	typedef enum logic {ST_IDLE = 1'b0, ST_ACCESS = 1'b1} clsbo_state_t;

	// One operation as presented by the fetch stage
	typedef struct packed {
		clsbo_op_t          op;        // Operation
		logic [4:0]         reg_a;     // Destination or source register
		clsbo_ptr_t         ptr_sel;   // Pointer pair
		clsbo_mode_t        ptr_mode;  // Plain, post-increment, pre-decrement
		logic [2:0]         bit_sel;   // Bit index or flag index
		logic [DISP_W-1:0]  disp;      // Displacement
		logic [ADDR_W-1:0]  addr;      // Absolute address, or I/O register number
	} clsbo_cmd_t;

	// Data-space request, held for one cycle
	typedef struct packed {
		logic [ADDR_W-1:0]  addr;
		logic [DATA_W-1:0]  wdata;
		logic               re;
		logic               we;
	} clsbo_mem_req_t;

	// One-hot mask of a bit index
	function automatic logic [7:0] bit_mask(input logic [2:0] sel);
		bit_mask = 8'h01 << sel;
	endfunction

	// Low register of a pointer pair
	function automatic logic [4:0] ptr_lo(input clsbo_ptr_t sel);
		ptr_lo = (sel == PTR_X) ? PTR_X_LO : ((sel == PTR_Y) ? PTR_Y_LO : PTR_Z_LO);
	endfunction

	// Operations that take the two-cycle data-space path
	function automatic logic is_access(input clsbo_op_t op);
		is_access = (op >= OP_POINTER_LOAD) && (op <= OP_IO_BIT_LOWER);
	endfunction

	// Operations that read a byte into a register
	function automatic logic is_load(input clsbo_op_t op);
		is_load = (op == OP_POINTER_LOAD) || (op == OP_OFFSET_LOAD) ||
			(op == OP_ABSOLUTE_LOAD) || (op == OP_STACK_RESTORE);
	endfunction

endpackage

// file: hdl/clsbo_addr_gen.sv
// Purpose: Effective address, pointer step and stack step for data-space operations
// Assumes: Purely combinational, fed by the accepted operation
// Notes:   All steps wrap at sixteen bits
`timescale 1ns/1ps
module clsbo_addr_gen (
	input  wire clsbo_pkg::clsbo_cmd_t  cmd,
	input  wire logic [15:0]            ptr,
	input  wire logic [15:0]            sp,
	output logic [15:0]                 eff_addr,
	output logic [15:0]                 ptr_next,
	output logic [15:0]                 sp_next
);

	// Address and step selection
	always_comb begin
		eff_addr = ptr;
		ptr_next = ptr;
		sp_next  = sp;
		unique case (cmd.op)
			// Indexed forms with optional step
			clsbo_pkg::OP_POINTER_LOAD, clsbo_pkg::OP_POINTER_WRITE: begin
				unique case (cmd.ptr_mode)
					clsbo_pkg::MODE_POST_INC: begin
						ptr_next = ptr + clsbo_pkg::PTR_STEP;
					end
					clsbo_pkg::MODE_PRE_DEC: begin
						ptr_next = ptr - clsbo_pkg::PTR_STEP;
						eff_addr = ptr - clsbo_pkg::PTR_STEP;
					end
					default: begin
						ptr_next = ptr;
					end
				endcase
			end
			clsbo_pkg::OP_OFFSET_LOAD, clsbo_pkg::OP_OFFSET_WRITE: begin
				eff_addr = ptr + {{(clsbo_pkg::ADDR_W - clsbo_pkg::DISP_W){1'b0}}, cmd.disp};
			end
			clsbo_pkg::OP_ABSOLUTE_LOAD, clsbo_pkg::OP_ABSOLUTE_WRITE: begin
				eff_addr = cmd.addr;
			end
			// I/O registers sit above the working registers
			clsbo_pkg::OP_IO_BIT_RAISE, clsbo_pkg::OP_IO_BIT_LOWER: begin
				eff_addr = clsbo_pkg::IO_BASE + {11'h000, cmd.addr[4:0]};
			end
			// store at top, then grow down
			clsbo_pkg::OP_STACK_SAVE: begin
				eff_addr = sp;
				sp_next  = sp - clsbo_pkg::PTR_STEP;
			end
			clsbo_pkg::OP_STACK_RESTORE: begin
				eff_addr = sp + clsbo_pkg::PTR_STEP;
				sp_next  = sp + clsbo_pkg::PTR_STEP;
			end
			default: begin
				eff_addr = ptr;
			end
		endcase
	end

endmodule

// file: hdl/clsbo_bit_alu.sv
// Purpose: Rotates, bit moves, I/O bit edits and flag set/clear
// Assumes: Combinational; caller chooses when results are written
// Notes:   Flags out equal flags in unless the operation touches them
`timescale 1ns/1ps
module clsbo_bit_alu (
	input  wire clsbo_pkg::clsbo_op_t   op,
	input  wire logic [7:0]             operand,
	input  wire logic [7:0]             flags,
	input  wire logic [2:0]             bit_sel,
	output logic [7:0]                  result,
	output logic [7:0]                  flags_next
);

	logic carry_new;    // Carry after a rotate

	// Result and flag computation
	always_comb begin
		result     = operand;
		flags_next = flags;
		carry_new  = flags[clsbo_pkg::FLAG_C];
		unique case (op)
			// old carry in at bit 0
			clsbo_pkg::OP_CARRY_ROTATE_UP: begin
				result    = {operand[6:0], flags[clsbo_pkg::FLAG_C]};
				carry_new = operand[7];
			end
			// old carry in at bit 7
			clsbo_pkg::OP_CARRY_ROTATE_DOWN: begin
				result    = {flags[clsbo_pkg::FLAG_C], operand[7:1]};
				carry_new = operand[0];
			end
			clsbo_pkg::OP_IO_BIT_RAISE: begin
				result = operand | clsbo_pkg::bit_mask(bit_sel);
			end
			clsbo_pkg::OP_IO_BIT_LOWER: begin
				result = operand & ~clsbo_pkg::bit_mask(bit_sel);
			end
			clsbo_pkg::OP_BIT_TO_TRANSFER_FLAG: begin
				flags_next[clsbo_pkg::FLAG_T] = operand[bit_sel];
			end
			clsbo_pkg::OP_TRANSFER_FLAG_TO_BIT: begin
				result = flags[clsbo_pkg::FLAG_T] ? (operand | clsbo_pkg::bit_mask(bit_sel))
					: (operand & ~clsbo_pkg::bit_mask(bit_sel));
			end
			clsbo_pkg::OP_FLAG_RAISE: begin
				flags_next = flags | clsbo_pkg::bit_mask(bit_sel);
			end
			clsbo_pkg::OP_FLAG_LOWER: begin
				flags_next = flags & ~clsbo_pkg::bit_mask(bit_sel);
			end
			default: begin
				result = operand;
			end
		endcase
		if ((op == clsbo_pkg::OP_CARRY_ROTATE_UP) || (op == clsbo_pkg::OP_CARRY_ROTATE_DOWN)) begin
			flags_next[clsbo_pkg::FLAG_C] = carry_new;
			flags_next[clsbo_pkg::FLAG_Z] = (result == 8'h00);
			flags_next[clsbo_pkg::FLAG_N] = result[7];
			flags_next[clsbo_pkg::FLAG_V] = result[7] ^ carry_new;
			flags_next[clsbo_pkg::FLAG_S] = carry_new;
		end
	end

endmodule

// file: hdl/clsbo_core.sv
// Purpose: Executes data transfer, stack, I/O bit and flag operations of an 8-bit core
// Assumes: Data space answers reads combinationally in the cycle the read strobe is high
// Notes:   Two-cycle operations hold READY low for one cycle; single-cycle ones never do
`timescale 1ns/1ps
module clsbo_core (
	input  wire logic                   CLK_SYS,
	input  wire logic                   RESET,
	input  wire logic                   START,
	input  wire clsbo_pkg::clsbo_cmd_t  CMD,
	output logic                        READY,
	output logic                        DONE,
	output clsbo_pkg::clsbo_mem_req_t   MEM_REQ,
	input  wire logic [7:0]             MEM_RDATA,
	output logic [7:0]                  FLAGS,
	output logic [15:0]                 STACK_PTR,
	input  wire logic [4:0]             VIEW_SEL,
	output logic [7:0]                  REG_VIEW
);

	logic [7:0]              regs [clsbo_pkg::REG_N];  // Working registers
	clsbo_pkg::clsbo_state_t state;                     // Sequencer state
	clsbo_pkg::clsbo_cmd_t   pend;                      // Operation in its access cycle
	clsbo_pkg::clsbo_cmd_t   alu_cmd;                   // Operation seen by the bit unit
	logic                    accept;                    // Operation taken this cycle
	logic                    two_cycle;                 // Accepted operation uses data space
	logic                    load_done;                 // Read data captured this cycle
	logic [4:0]              lo_idx;                    // Low register of selected pointer
	logic [4:0]              hi_idx;                    // High register of selected pointer
	logic [15:0]             ptr_val;                   // Selected pointer value
	logic [15:0]             eff_addr;                  // Effective data address
	logic [15:0]             ptr_next;                  // Pointer after its step
	logic [15:0]             sp_next;                   // Stack pointer after its step
	logic                    ptr_step;                  // Pointer written back
	logic                    alu_reg_wr;                // Bit unit writes a register
	logic                    alu_flag_wr;               // Bit unit writes flags
	logic [7:0]              src_val;                   // Register operand
	logic [7:0]              alu_in;                    // Bit unit operand
	logic [7:0]              alu_result;                // Bit unit result
	logic [7:0]              alu_flags;                 // Bit unit flags

	// Operand selection and decode
	always_comb begin
		accept     = START && READY;
		two_cycle  = clsbo_pkg::is_access(CMD.op);
		load_done  = (state == clsbo_pkg::ST_ACCESS) && clsbo_pkg::is_load(pend.op);
		lo_idx     = clsbo_pkg::ptr_lo(CMD.ptr_sel);
		hi_idx     = lo_idx | 5'h01;
		ptr_val    = {regs[hi_idx], regs[lo_idx]};
		src_val    = regs[CMD.reg_a];
		alu_cmd    = (state == clsbo_pkg::ST_ACCESS) ? pend : CMD;
		alu_in     = (state == clsbo_pkg::ST_ACCESS) ? MEM_RDATA : src_val;
		ptr_step   = ((CMD.op == clsbo_pkg::OP_POINTER_LOAD) || (CMD.op == clsbo_pkg::OP_POINTER_WRITE))
			&& (CMD.ptr_mode != clsbo_pkg::MODE_PLAIN);
		alu_reg_wr = (CMD.op == clsbo_pkg::OP_CARRY_ROTATE_UP) || (CMD.op == clsbo_pkg::OP_CARRY_ROTATE_DOWN)
			|| (CMD.op == clsbo_pkg::OP_TRANSFER_FLAG_TO_BIT);
		alu_flag_wr = (CMD.op == clsbo_pkg::OP_CARRY_ROTATE_UP) || (CMD.op == clsbo_pkg::OP_CARRY_ROTATE_DOWN)
			|| (CMD.op == clsbo_pkg::OP_BIT_TO_TRANSFER_FLAG) || (CMD.op == clsbo_pkg::OP_FLAG_RAISE)
			|| (CMD.op == clsbo_pkg::OP_FLAG_LOWER);
	end

	// Address and step generator
	clsbo_addr_gen u_addr (
		.cmd      (CMD),
		.ptr      (ptr_val),
		.sp       (STACK_PTR),
		.eff_addr (eff_addr),
		.ptr_next (ptr_next),
		.sp_next  (sp_next)
	);

	// Rotate, bit and flag unit
	clsbo_bit_alu u_alu (
		.op         (alu_cmd.op),
		.operand    (alu_in),
		.flags      (FLAGS),
		.bit_sel    (alu_cmd.bit_sel),
		.result     (alu_result),
		.flags_next (alu_flags)
	);

	// Sequencer: idle, or the second cycle of an access
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			state <= clsbo_pkg::ST_IDLE;
			READY <= 1'b1;
			pend  <= '0;
		end else if (accept && two_cycle) begin
			state <= clsbo_pkg::ST_ACCESS;
			READY <= 1'b0;
			pend  <= CMD;
		end else if (state == clsbo_pkg::ST_ACCESS) begin
			state <= clsbo_pkg::ST_IDLE;
			READY <= 1'b1;
		end
	end

	// Completion pulse
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			DONE <= 1'b0;
		end else begin
			DONE <= (accept && !two_cycle) || (state == clsbo_pkg::ST_ACCESS);
		end
	end

	// Data-space request
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			MEM_REQ <= '0;
		end else if (accept && two_cycle) begin
			MEM_REQ.addr  <= eff_addr;
			MEM_REQ.wdata <= src_val;
			MEM_REQ.re    <= clsbo_pkg::is_load(CMD.op) || (CMD.op == clsbo_pkg::OP_IO_BIT_RAISE)
				|| (CMD.op == clsbo_pkg::OP_IO_BIT_LOWER);
			MEM_REQ.we    <= (CMD.op == clsbo_pkg::OP_POINTER_WRITE) || (CMD.op == clsbo_pkg::OP_OFFSET_WRITE)
				|| (CMD.op == clsbo_pkg::OP_ABSOLUTE_WRITE) || (CMD.op == clsbo_pkg::OP_STACK_SAVE);
		end else if ((state == clsbo_pkg::ST_ACCESS) && !clsbo_pkg::is_load(pend.op)
			&& (pend.op != clsbo_pkg::OP_POINTER_WRITE) && (pend.op != clsbo_pkg::OP_OFFSET_WRITE)
			&& (pend.op != clsbo_pkg::OP_ABSOLUTE_WRITE) && (pend.op != clsbo_pkg::OP_STACK_SAVE)) begin
			MEM_REQ.wdata <= alu_result;
			MEM_REQ.re    <= 1'b0;
			MEM_REQ.we    <= 1'b1;
		end else begin
			MEM_REQ.re <= 1'b0;
			MEM_REQ.we <= 1'b0;
		end
	end

	// Working registers
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			for (int i = 0; i < clsbo_pkg::REG_N; i++) begin
				regs[i] <= clsbo_pkg::REG_RESET;
			end
		end else if (load_done) begin
			regs[pend.reg_a] <= MEM_RDATA;
		end else if (accept) begin
			if (ptr_step) begin
				regs[lo_idx] <= ptr_next[7:0];
				regs[hi_idx] <= ptr_next[15:8];
			end
			if (alu_reg_wr) begin
				regs[CMD.reg_a] <= alu_result;
			end
		end
	end

	// Flag register
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			FLAGS <= clsbo_pkg::FLAGS_RESET;
		end else if (accept && alu_flag_wr) begin
			FLAGS <= alu_flags;
		end
	end

	// Stack pointer
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			STACK_PTR <= clsbo_pkg::SP_RESET;
		end else if (accept && ((CMD.op == clsbo_pkg::OP_STACK_SAVE) || (CMD.op == clsbo_pkg::OP_STACK_RESTORE))) begin
			STACK_PTR <= sp_next;
		end
	end

	// Register observation port
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			REG_VIEW <= clsbo_pkg::REG_RESET;
		end else begin
			REG_VIEW <= regs[VIEW_SEL];
		end
	end

	// Checks
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RESET);

	logic [7:0] io_mask_p;   // Mask of the pending I/O bit
	logic [7:0] t_mask;      // Mask of the accepted bit index
	logic [7:0] src_bit;     // Selected source bit, widened
	assign io_mask_p = clsbo_pkg::bit_mask(pend.bit_sel);
	assign t_mask    = clsbo_pkg::bit_mask(CMD.bit_sel);
	assign src_bit   = {7'h00, src_val[CMD.bit_sel]};

	a_load_two_cycles: assert property (accept && clsbo_pkg::is_load(CMD.op) |=>
		(MEM_REQ.re && !READY) ##1 (DONE && READY)) else $error("load does not finish in two cycles");

	a_postinc_pointer: assert property (accept && ptr_step && (CMD.ptr_mode == clsbo_pkg::MODE_POST_INC) |=>
		(MEM_REQ.addr == $past(ptr_val)) && ({regs[$past(hi_idx)], regs[$past(lo_idx)]} == $past(ptr_val) + 16'h0001))
		else $error("post-increment address or step wrong");

	a_predec_addr: assert property (accept && ptr_step && (CMD.ptr_mode == clsbo_pkg::MODE_PRE_DEC) |=>
		(MEM_REQ.addr == $past(ptr_val) - 16'h0001)) else $error("pre-decrement address wrong");

	a_offset_keeps: assert property (accept && ((CMD.op == clsbo_pkg::OP_OFFSET_LOAD)
		|| (CMD.op == clsbo_pkg::OP_OFFSET_WRITE)) |=>
		({regs[$past(hi_idx)], regs[$past(lo_idx)]} == $past(ptr_val))
		&& (MEM_REQ.addr == $past(ptr_val) + {10'h000, $past(CMD.disp)}))
		else $error("offset access moved the pointer or missed its address");

	a_store_data: assert property (accept && (CMD.op == clsbo_pkg::OP_ABSOLUTE_WRITE) |=>
		MEM_REQ.we && (MEM_REQ.wdata == $past(src_val)) && (MEM_REQ.addr == $past(CMD.addr)) && $stable(FLAGS))
		else $error("absolute write wrong");

	a_push_stack: assert property (accept && (CMD.op == clsbo_pkg::OP_STACK_SAVE) |=>
		MEM_REQ.we && (MEM_REQ.addr == $past(STACK_PTR)) && (STACK_PTR == $past(STACK_PTR) - 16'h0001))
		else $error("stack save wrong");

	a_io_raise: assert property ((state == clsbo_pkg::ST_ACCESS) && (pend.op == clsbo_pkg::OP_IO_BIT_RAISE) |=>
		MEM_REQ.we && (MEM_REQ.wdata == ($past(MEM_RDATA) | $past(io_mask_p)))) else $error("I/O raise wrong");

	a_io_lower: assert property ((state == clsbo_pkg::ST_ACCESS) && (pend.op == clsbo_pkg::OP_IO_BIT_LOWER) |=>
		MEM_REQ.we && (MEM_REQ.wdata == ($past(MEM_RDATA) & ~$past(io_mask_p)))) else $error("I/O lower wrong");

	a_rotate_carry: assert property (accept && (CMD.op == clsbo_pkg::OP_CARRY_ROTATE_UP) |=>
		(FLAGS[clsbo_pkg::FLAG_C] == $past(src_val[7])) && READY) else $error("rotate up carry wrong");

	a_transfer_bit: assert property (accept && (CMD.op == clsbo_pkg::OP_BIT_TO_TRANSFER_FLAG) |=>
		(FLAGS[clsbo_pkg::FLAG_T] == $past(src_bit[0]))) else $error("transfer flag copy wrong");

	a_flag_only: assert property (accept && (CMD.op == clsbo_pkg::OP_FLAG_RAISE) |=>
		(FLAGS == ($past(FLAGS) | $past(t_mask)))) else $error("flag raise touched other flags");

	c_load: cover property (accept && (CMD.op == clsbo_pkg::OP_POINTER_LOAD) ##2 DONE);
	c_io_raise: cover property (accept && (CMD.op == clsbo_pkg::OP_IO_BIT_RAISE) ##2 MEM_REQ.we);
	c_rotate: cover property (accept && (CMD.op == clsbo_pkg::OP_CARRY_ROTATE_DOWN) ##1 DONE);
	c_restore: cover property (accept && (CMD.op == clsbo_pkg::OP_STACK_RESTORE) ##2 READY);

endmodule

// file: dv/clsbo_mem_model.sv
// Purpose: Data space seen by the core, reads answered in the strobe cycle
// Assumes: One request per operation, a read then a write for I/O bit edits, re and we never together
// Notes:   Off-strobe read data shows the inverse of the last byte read
`timescale 1ns/1ps
module clsbo_mem_model (
	input  wire logic                     clk,
	input  wire clsbo_pkg::clsbo_mem_req_t req,
	output logic [7:0]                    rdata
);
	logic [7:0] mem [65536];   // Whole data space
	logic [7:0] last = 8'h00;  // Last byte handed out

	always_comb rdata = req.re ? mem[req.addr] : ~last;

	always @(posedge clk) begin
		if (req.re) last <= mem[req.addr];
		if (req.we) mem[req.addr] <= req.wdata;
	end
endmodule

// file: dv/testbench.sv
// Purpose: Self-checking bench, random operations against a reference model
// Assumes: Memory model preloaded from the bench
// Notes:   Writes and flags are checked as they appear
`timescale 1ns/1ps
module testbench;
	logic                      CLK_SYS, RESET, START;  // Clock, reset, request
	clsbo_pkg::clsbo_cmd_t     CMD;                    // Operation
	logic                      READY, DONE;            // Handshake
	clsbo_pkg::clsbo_mem_req_t MEM_REQ;                // Data-space request
	logic [7:0]                MEM_RDATA, FLAGS, REG_VIEW;
	logic [15:0]               STACK_PTR;
	logic [4:0]                VIEW_SEL;
	int                        miscompares, total_checks;
	int                        seed = 97;
	logic [7:0]                r [32];     // Reference registers
	logic [7:0]                sh [65536]; // Reference data space
	logic [7:0]                f;          // Reference flags, I T H S V N Z C
	logic [15:0]               sp;         // Reference stack pointer
	logic [23:0]               mq [$];     // Expected writes
	logic [7:0]                fq [$];     // Expected flags per completion
	clsbo_pkg::clsbo_cmd_t     c;

	clsbo_core uut (.CLK_SYS(CLK_SYS), .RESET(RESET), .START(START), .CMD(CMD), .READY(READY),
		.DONE(DONE), .MEM_REQ(MEM_REQ), .MEM_RDATA(MEM_RDATA), .FLAGS(FLAGS),
		.STACK_PTR(STACK_PTR), .VIEW_SEL(VIEW_SEL), .REG_VIEW(REG_VIEW));
	clsbo_mem_model mem_i (.clk(CLK_SYS), .req(MEM_REQ), .rdata(MEM_RDATA));

	// Clock, 10 ns period
	initial begin
		CLK_SYS = 1'b0;
		forever #5 CLK_SYS = ~CLK_SYS;
	end

	// Compare seen against expected
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// Verdict and end of run
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// Note an expected write
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		sh[a] = d;
		mq.push_back({a, d});
	endtask

	// Issue one operation and replay it on the reference
	task automatic go(input clsbo_pkg::clsbo_cmd_t k);
		logic [15:0] p, a;
		logic [7:0]  v, o;
		logic [4:0]  lo;
		int          n;
		n = 0;
		while (READY !== 1'b1) begin
			START = 1'b0;
			@(posedge CLK_SYS);
			#1;
			if (++n > 20) begin
				miscompares++;
				wrap_up();
			end
		end
		lo = 5'h1a + {k.ptr_sel, 1'b0};
		p = {r[lo+5'h01], r[lo]};
		v = r[k.reg_a];
		case (k.op)
			clsbo_pkg::OP_POINTER_LOAD, clsbo_pkg::OP_POINTER_WRITE: begin
				if (k.ptr_mode == clsbo_pkg::MODE_PRE_DEC) p = p - 16'h0001;
				a = p;
				if (k.ptr_mode == clsbo_pkg::MODE_POST_INC) p = p + 16'h0001;
				{r[lo+5'h01], r[lo]} = p;
				if (k.op == clsbo_pkg::OP_POINTER_LOAD) r[k.reg_a] = sh[a];
				else wr(a, v);
			end
			clsbo_pkg::OP_OFFSET_LOAD: r[k.reg_a] = sh[p + 16'(k.disp)];
			clsbo_pkg::OP_OFFSET_WRITE: wr(p + 16'(k.disp), v);
			clsbo_pkg::OP_ABSOLUTE_LOAD: r[k.reg_a] = sh[k.addr];
			clsbo_pkg::OP_ABSOLUTE_WRITE: wr(k.addr, v);
			clsbo_pkg::OP_STACK_SAVE: begin
				wr(sp, v);
				sp = sp - 16'h0001;
			end
			clsbo_pkg::OP_STACK_RESTORE: begin
				sp = sp + 16'h0001;
				r[k.reg_a] = sh[sp];
			end
			clsbo_pkg::OP_IO_BIT_RAISE, clsbo_pkg::OP_IO_BIT_LOWER: begin
				a = 16'h0020 + 16'(k.addr[4:0]);
				o = sh[a];
				o[k.bit_sel] = (k.op == clsbo_pkg::OP_IO_BIT_RAISE);
				wr(a, o);
			end
			clsbo_pkg::OP_CARRY_ROTATE_UP, clsbo_pkg::OP_CARRY_ROTATE_DOWN: begin
				o = (k.op == clsbo_pkg::OP_CARRY_ROTATE_UP) ? {v[6:0], f[0]} : {f[0], v[7:1]};
				f[0] = (k.op == clsbo_pkg::OP_CARRY_ROTATE_UP) ? v[7] : v[0];
				f[1] = (o == 8'h00);
				f[2] = o[7];
				f[3] = f[2] ^ f[0];
				f[4] = f[2] ^ f[3];
				r[k.reg_a] = o;
			end
			clsbo_pkg::OP_BIT_TO_TRANSFER_FLAG: f[6] = v[k.bit_sel];
			clsbo_pkg::OP_TRANSFER_FLAG_TO_BIT: r[k.reg_a][k.bit_sel] = f[6];
			clsbo_pkg::OP_FLAG_RAISE: f[k.bit_sel] = 1'b1;
			clsbo_pkg::OP_FLAG_LOWER: f[k.bit_sel] = 1'b0;
			default: ;
		endcase
		fq.push_back(f);
		START = 1'b1;
		CMD = k;
		@(posedge CLK_SYS);
		#1;
		check(READY, (k.op < clsbo_pkg::OP_POINTER_LOAD || k.op > clsbo_pkg::OP_IO_BIT_LOWER));
	endtask

	// Results taken off the queues as they appear
	always @(posedge CLK_SYS) begin
		if (RESET === 1'b0 && DONE === 1'b1) begin
			if (fq.size() > 0) check(FLAGS, fq.pop_front());
			else check(1, 0);
		end
		if (RESET === 1'b0 && MEM_REQ.we === 1'b1) begin
			if (mq.size() > 0) check({MEM_REQ.addr, MEM_REQ.wdata}, mq.pop_front());
			else check(2, 0);
		end
	end

	// Main sequence
	initial begin
		miscompares = 0;
		total_checks = 0;
		RESET = 1'b1;
		START = 1'b0;
		CMD = '0;
		VIEW_SEL = 5'h00;
		f = 8'h00;
		sp = clsbo_pkg::SP_RESET;
		for (int i = 0; i < 32; i++) r[i] = 8'h00;
		for (int i = 0; i < 65536; i++) begin
			sh[i] = 8'($random(seed));
			mem_i.mem[i] = sh[i];
		end
		sh[16'h0100] = 8'hff;
		mem_i.mem[16'h0100] = 8'hff;
		repeat (20) @(posedge CLK_SYS);
		#1;
		RESET = 1'b0;
		check({STACK_PTR, FLAGS}, {clsbo_pkg::SP_RESET, 8'h00});
		// Pointer at all ones, step up to zero, then down to all ones
		c = '0;
		c.op = clsbo_pkg::OP_ABSOLUTE_LOAD;
		c.addr = 16'h0100;
		c.reg_a = 5'h1e;
		go(c);
		c.reg_a = 5'h1f;
		go(c);
		c = '{clsbo_pkg::OP_POINTER_LOAD, 5'h03, clsbo_pkg::PTR_Z, clsbo_pkg::MODE_POST_INC, 3'h0, 6'h00, 16'h0000};
		go(c);
		c.op = clsbo_pkg::OP_POINTER_WRITE;
		c.ptr_mode = clsbo_pkg::MODE_PRE_DEC;
		go(c);
		$display("test pointer wrap done");
		// Random operations of every kind
		for (int i = 0; i < 400; i++) begin
			logic [31:0] x, y;
			x = $random(seed);
			y = $random(seed);
			c.op = clsbo_pkg::clsbo_op_t'(x[4:0] % 5'd17);
			c.reg_a = x[9:5];
			c.ptr_sel = clsbo_pkg::clsbo_ptr_t'(x[11:10] % 2'd3);
			c.ptr_mode = clsbo_pkg::clsbo_mode_t'(x[13:12] % 2'd3);
			c.bit_sel = x[16:14];
			c.disp = x[22:17];
			c.addr = y[15:0];
			go(c);
		end
		START = 1'b0;
		repeat (3) @(posedge CLK_SYS);
		#1;
		$display("test random operations done");
		check(STACK_PTR, sp);
		check(mq.size() + fq.size(), 0);
		for (int i = 0; i < 32; i++) begin
			VIEW_SEL = 5'(i);
			@(posedge CLK_SYS);
			#1;
			check(REG_VIEW, r[i]);
		end
		$display("test register contents done");
		wrap_up();
	end
endmodule
